// [design/ecpr_port_regs.sv]
`timescale 1ns/100ps
`include "ecpr_defines.svh"
module ecpr_port_regs (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] base_addr_i,
  input wire logic [15:0] host_addr_i,
  input wire logic aen_i,
  input wire logic host_read_strobe_n_i,
  input wire logic host_write_strobe_n_i,
  input wire logic [7:0] host_data_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe_n_o,
  input wire logic dma_tc_i,
  input wire logic irq_level_i,
  input wire logic [3:0] irq_sel_i,
  input wire logic [1:0] dma_sel_i,
  input wire logic fault_input_n_i,
  input wire logic select_i,
  input wire logic paper_error_input_i,
  input wire logic acknowledge_input_n_i,
  input wire logic busy_i,
  input wire logic [7:0] port_data_pins_i,
  output logic [7:0] port_data_pins_o,
  output logic port_data_oe_n_o,
  output logic strobe_output_n_o,
  output logic autofeed_output_n_o,
  output logic initialize_output_n_o,
  output logic select_in_output_n_o,
  output logic irq_o
);

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function automatic logic [2:0] irq_code(input logic [3:0] sel);
    unique case (sel)
      4'hF: irq_code = 3'h6;
      4'hE: irq_code = 3'h5;
      4'hB: irq_code = 3'h4;
      4'hA: irq_code = 3'h3;
      4'h9: irq_code = 3'h2;
      4'h7: irq_code = 3'h1;
      4'h5: irq_code = 3'h7;
      default: irq_code = 3'h0;
    endcase
  endfunction : irq_code

  function automatic logic [2:0] dma_code(input logic [1:0] sel);
    dma_code = {1'b0, sel};
  endfunction : dma_code

  function automatic logic is_pio(input ecpr_pkg::ecpr_mode_t m);
    is_pio = (m == `ECPR_MODE_COMPAT) || (m == `ECPR_MODE_BYTE);
  endfunction : is_pio

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  ecpr_pkg::ecpr_host_s host_in;
  ecpr_pkg::ecpr_host_s host_s1;
  ecpr_pkg::ecpr_host_s host_s2;
  ecpr_pkg::ecpr_pins_s pins_in;
  ecpr_pkg::ecpr_pins_s pins_s1;
  ecpr_pkg::ecpr_pins_s pins_s2;
  logic wr_d_r;
  logic rd_d_r;
  logic ack_d_r;

  assign host_in = '{wr_n: host_write_strobe_n_i, rd_n: host_read_strobe_n_i, aen: aen_i,
                     addr: host_addr_i, data: host_data_i};
  assign pins_in = '{fault: fault_input_n_i, select: select_i, paper_error_input: paper_error_input_i,
                     ack: acknowledge_input_n_i, busy: busy_i, tc: dma_tc_i,
                     irq_level: irq_level_i, pd: port_data_pins_i};

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      host_s1 <= '{wr_n: 1'b1, rd_n: 1'b1, aen: 1'b1, addr: 16'h0000, data: 8'h00};
      host_s2 <= '{wr_n: 1'b1, rd_n: 1'b1, aen: 1'b1, addr: 16'h0000, data: 8'h00};
      // acknowledge starts at its idle high level, so release gives no false edge
      pins_s1 <= '{ack: 1'b1, default: '0};
      pins_s2 <= '{ack: 1'b1, default: '0};
      wr_d_r <= 1'b1;
      rd_d_r <= 1'b1;
      ack_d_r <= 1'b1;
    end else begin
      host_s1 <= host_in;
      host_s2 <= host_s1;
      pins_s1 <= pins_in;
      pins_s2 <= pins_s1;
      wr_d_r <= host_s2.wr_n;
      rd_d_r <= host_s2.rd_n;
      ack_d_r <= pins_s2.ack;
    end
  end

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  logic [7:0] data_r;
  logic [5:0] ctrl_r;
  ecpr_pkg::ecpr_mode_t mode_r;
  logic err_dis_r;
  logic dma_en_r;
  logic svc_r;
  logic [4:0] cnt_r;
  logic [7:0] last_byte_r;
  logic [8:0] mem_q;

  wire [15:0] off = host_s2.addr - base_addr_i;
  wire hit = ~host_s2.aen;
  wire sel_data = hit && (off == `ECPR_OFF_DATA);
  wire sel_status = hit && (off == `ECPR_OFF_STATUS);
  wire sel_ctrl = hit && (off == `ECPR_OFF_CONTROL);
  wire sel_queue = hit && (off == `ECPR_OFF_QUEUE);
  wire sel_res = hit && (off == `ECPR_OFF_RESOURCE);
  wire sel_ecr = hit && (off == `ECPR_OFF_EXTCTRL);
  // write data is taken on the rising edge of the write strobe
  wire wr_ev = host_s2.wr_n & ~wr_d_r;
  wire rd_ev = host_s2.rd_n & ~rd_d_r;
  wire rd_act = ~host_s2.rd_n & hit;

  wire m_pio = is_pio(mode_r);
  wire m_stdq = (mode_r == `ECPR_MODE_STDQ);
  wire m_ecp = (mode_r == `ECPR_MODE_ECP);
  wire m_test = (mode_r == `ECPR_MODE_TEST);
  wire m_cfg = (mode_r == `ECPR_MODE_CONFIG);
  wire hs_mode = m_stdq | m_ecp;
  // direction ignored in modes 000 and 010
  wire dir_eff = ((mode_r == `ECPR_MODE_COMPAT) || m_stdq) ? 1'b0 : ctrl_r[`ECPR_CTL_DIR];

  wire full = (cnt_r == `ECPR_FIFO_DEPTH);
  wire empty = (cnt_r == 5'h00);
  wire [4:0] free = `ECPR_FIFO_DEPTH - cnt_r;

  // ----------------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------------
  // status layout
  wire [7:0] status_val = {~pins_s2.busy, pins_s2.ack, pins_s2.paper_error_input, pins_s2.select, pins_s2.fault, 3'h0};
  wire [7:0] res_val = {1'b0, pins_s2.irq_level, irq_code(irq_sel_i), dma_code(dma_sel_i)};
  wire [7:0] ecr_val = {mode_r, err_dis_r, dma_en_r, svc_r, full, empty};
  // underrun rereads the last byte taken
  wire [7:0] queue_val = empty ? last_byte_r : mem_q[7:0];
  wire [7:0] data_val = pins_s2.pd;
  wire [7:0] rd_mux = (sel_data && m_pio) ? data_val :
                      sel_status ? status_val :
                      sel_ctrl ? {2'b00, ctrl_r} :
                      (sel_queue && m_cfg) ? `ECPR_IMPL_INFO :
                      (sel_queue && (hs_mode || m_test)) ? queue_val :
                      (sel_res && m_cfg) ? res_val :
                      sel_ecr ? ecr_val : 8'h00;
  wire rd_mapped = sel_data | sel_status | sel_ctrl | sel_queue | sel_res | sel_ecr;

  // ----------------------------------------------------------------------
  // queue control
  // ----------------------------------------------------------------------
  ecpr_pkg::ecpr_xfer_e xf_r;
  ecpr_pkg::ecpr_xfer_e xf_nxt;
  logic [3:0] wr_ptr_r;
  logic [3:0] rd_ptr_r;
  logic [6:0] rle_cnt_r;
  logic rle_arm_r;
  logic [7:0] rep_left_r;
  logic [7:0] rep_byte_r;
  logic [7:0] xfer_byte_r;
  logic tag_r;

  wire host_push = wr_ev && ((sel_queue && (m_stdq || m_test || (m_ecp && !dir_eff)))
                             || (sel_data && m_ecp && !dir_eff));
  wire host_tag = sel_data;
  // host pops in ECP reverse and test mode
  wire host_pop = rd_ev && sel_queue && ((m_ecp && dir_eff) || m_test);
  wire rev_cap = (xf_r == ecpr_pkg::XF_IDLE) && m_ecp && dir_eff && !pins_s2.ack
                 && (rep_left_r == 8'h00) && !full;
  wire cap_cmd = ~pins_s2.busy;
  // a command byte below 0x80 is a repeat count
  wire cap_rle = rev_cap && cap_cmd && !pins_s2.pd[7];
  wire cap_rep = rev_cap && !cap_cmd && rle_arm_r;
  wire cap_push = rev_cap && !cap_rle && !cap_rep;
  wire rep_push = (rep_left_r != 8'h00) && !full;
  wire fwd_pop = (xf_r == ecpr_pkg::XF_STROBE) && pins_s2.busy;
  wire push_req = host_push | cap_push | rep_push;
  wire [8:0] push_word = host_push ? {host_tag, host_s2.data} :
                         cap_push ? {cap_cmd, pins_s2.pd} : {1'b0, rep_byte_r};
  // never stall; refuse only what cannot fit or is missing
  wire push_ok = push_req && !full;
  wire pop_ok = (host_pop || fwd_pop) && !empty;
  // compatibility and byte modes hold the queue in reset
  wire fifo_clr = m_pio;
  wire [4:0] cnt_nxt = fifo_clr ? 5'h00 : cnt_r + {4'h0, push_ok} - {4'h0, pop_ok};

  ecpr_fifo_mem u_mem (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .wr_en_i(push_ok),
    .wr_addr_i(wr_ptr_r),
    .wr_data_i(push_word),
    .rd_addr_i(rd_ptr_r),
    .rd_data_o(mem_q)
  );

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_r <= 4'h0;
      rd_ptr_r <= 4'h0;
      cnt_r <= 5'h00;
      last_byte_r <= 8'h00;
    end else begin
      wr_ptr_r <= fifo_clr ? 4'h0 : wr_ptr_r + {3'h0, push_ok};
      rd_ptr_r <= fifo_clr ? 4'h0 : rd_ptr_r + {3'h0, pop_ok};
      cnt_r <= cnt_nxt;
      if (host_pop && !empty) begin
        last_byte_r <= mem_q[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // line handshake engine
  // ----------------------------------------------------------------------
  always_comb begin
    xf_nxt = xf_r;
    unique case (xf_r)
      ecpr_pkg::XF_IDLE: begin
        if (hs_mode && !dir_eff && !empty) begin
          xf_nxt = ecpr_pkg::XF_SETUP;
        end else if (rev_cap) begin
          xf_nxt = ecpr_pkg::XF_REV;
        end
      end
      ecpr_pkg::XF_SETUP: xf_nxt = ecpr_pkg::XF_STROBE;
      ecpr_pkg::XF_STROBE: if (pins_s2.busy) xf_nxt = ecpr_pkg::XF_HOLD;
      ecpr_pkg::XF_HOLD: if (!pins_s2.busy) xf_nxt = ecpr_pkg::XF_IDLE;
      ecpr_pkg::XF_REV: if (pins_s2.ack) xf_nxt = ecpr_pkg::XF_IDLE;
    endcase
    // leaving a transfer mode drops the handshake at once
    if (!hs_mode) begin
      xf_nxt = ecpr_pkg::XF_IDLE;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xf_r <= ecpr_pkg::XF_IDLE;
      xfer_byte_r <= 8'h00;
      tag_r <= 1'b0;
    end else begin
      xf_r <= xf_nxt;
      if (xf_r == ecpr_pkg::XF_SETUP) begin
        xfer_byte_r <= mem_q[7:0];
        tag_r <= mem_q[8];
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rle_cnt_r <= 7'h00;
      rle_arm_r <= 1'b0;
      rep_left_r <= 8'h00;
      rep_byte_r <= 8'h00;
    end else if (fifo_clr) begin
      rle_arm_r <= 1'b0;
      rep_left_r <= 8'h00;
    end else if (cap_rle) begin
      rle_cnt_r <= pins_s2.pd[6:0];
      rle_arm_r <= 1'b1;
    end else if (cap_rep) begin
      rep_left_r <= {1'b0, rle_cnt_r} + 8'h01;
      rep_byte_r <= pins_s2.pd;
      rle_arm_r <= 1'b0;
    end else if (rep_push) begin
      rep_left_r <= rep_left_r - 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  wire [2:0] mode_wr = host_s2.data[`ECPR_ECR_MODE_HI:`ECPR_ECR_MODE_LO];
  // from a transfer mode only the two plain modes may be entered
  wire mode_ok = m_pio || is_pio(mode_wr);
  wire svc_set = !svc_r && (hs_mode || m_test)
                 && ((dma_en_r && pins_s2.tc)
                     || (!dma_en_r && !dir_eff && (free >= `ECPR_WRITE_THRESHOLD))
                     || (!dma_en_r && dir_eff && (cnt_r >= `ECPR_READ_THRESHOLD)));

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_r <= `ECPR_DATA_RST;
      ctrl_r <= `ECPR_CTRL_RST;
      mode_r <= `ECPR_MODE_RST;
      err_dis_r <= 1'b0;
      dma_en_r <= 1'b0;
      svc_r <= `ECPR_SVC_RST;
    end else begin
      if (wr_ev && sel_data && m_pio) begin
        data_r <= host_s2.data;
      end
      if (wr_ev && sel_ctrl) begin
        ctrl_r[4:0] <= host_s2.data[4:0];
        // direction changes only in byte mode
        if (mode_r == `ECPR_MODE_BYTE) begin
          ctrl_r[`ECPR_CTL_DIR] <= host_s2.data[`ECPR_CTL_DIR];
        end
      end
      if (wr_ev && sel_ecr) begin
        if (mode_ok) begin
          mode_r <= mode_wr;
        end
        err_dis_r <= host_s2.data[`ECPR_ECR_ERRDIS];
        dma_en_r <= host_s2.data[`ECPR_ECR_DMA_ENABLE_BIT];
      end
      // set wins over a software clear in the same cycle
      if (svc_set) begin
        svc_r <= 1'b1;
      end else if (wr_ev && sel_ecr) begin
        svc_r <= host_s2.data[`ECPR_ECR_SVC];
      end
    end
  end

  // ----------------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------------
  wire ack_rise = pins_s2.ack & ~ack_d_r;
  // tag shown only once the new byte is loaded; avoids a stale-tag glitch in setup
  wire fwd_act = ((xf_r == ecpr_pkg::XF_STROBE) || (xf_r == ecpr_pkg::XF_HOLD)) && !dir_eff;
  wire [7:0] pd_nxt = (hs_mode && !dir_eff) ? xfer_byte_r : m_test ? mem_q[7:0] : data_r;
  wire strobe_nxt = hs_mode ? (xf_r != ecpr_pkg::XF_STROBE) : ~ctrl_r[`ECPR_CTL_STROBE];
  wire afd_nxt = m_ecp ? (dir_eff ? (xf_r == ecpr_pkg::XF_REV) : ~(tag_r && fwd_act))
                       : ~ctrl_r[`ECPR_CTL_AUTOFEED];

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      host_data_o <= 8'h00;
      host_data_oe_n_o <= 1'b1;
      port_data_pins_o <= `ECPR_DATA_RST;
      port_data_oe_n_o <= 1'b0;
      strobe_output_n_o <= 1'b1;
      autofeed_output_n_o <= 1'b1;
      initialize_output_n_o <= 1'b0;
      select_in_output_n_o <= 1'b1;
      irq_o <= 1'b0;
    end else begin
      host_data_o <= rd_act ? rd_mux : 8'h00;
      host_data_oe_n_o <= ~(rd_act && rd_mapped);
      // pins show register, transfer byte or queue head
      port_data_pins_o <= pd_nxt;
      // direction bit releases the data pins
      port_data_oe_n_o <= dir_eff;
      strobe_output_n_o <= strobe_nxt;
      autofeed_output_n_o <= afd_nxt;
      initialize_output_n_o <= ctrl_r[`ECPR_CTL_INIT];
      select_in_output_n_o <= ~ctrl_r[`ECPR_CTL_SELIN];
      irq_o <= ctrl_r[`ECPR_CTL_ACKIEN] & ack_rise;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_status_low;
    rd_act && sel_status |=> host_data_o[2:0] == 3'h0 && host_data_o[7] == !$past(pins_s2.busy);
  endproperty
  a_status_low: assert property (p_status_low) else $error("status low bits or busy wrong");

  property p_impl_info;
    rd_act && sel_queue && m_cfg |=> host_data_o == `ECPR_IMPL_INFO;
  endproperty
  a_impl_info: assert property (p_impl_info) else $error("implementation code wrong");

  property p_strobe;
    !hs_mode |=> strobe_output_n_o == !$past(ctrl_r[`ECPR_CTL_STROBE]);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe not inverted control bit");

  property p_compat_drive;
    mode_r == `ECPR_MODE_COMPAT |=> !port_data_oe_n_o;
  endproperty
  a_compat_drive: assert property (p_compat_drive) else $error("compat mode released pins");

  property p_ack_irq;
    ctrl_r[`ECPR_CTL_ACKIEN] && ack_rise |=> irq_o ##1 !irq_o;
  endproperty
  a_ack_irq: assert property (p_ack_irq) else $error("ack interrupt missing");

  property p_overrun;
    m_test && wr_ev && sel_queue && full && !pop_ok |=> cnt_r == $past(cnt_r) && full;
  endproperty
  a_overrun: assert property (p_overrun) else $error("write into full test queue counted");

  property p_underrun;
    m_test && rd_act && sel_queue && empty |=> host_data_o == $past(last_byte_r);
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun did not reread last byte");

  property p_service;
    svc_set |=> svc_r ##1 (svc_r || $past(wr_ev && sel_ecr));
  endproperty
  a_service: assert property (p_service) else $error("service flag not held");

  property p_mode_lock;
    wr_ev && sel_ecr && !m_pio && !is_pio(mode_wr) |=> $stable(mode_r);
  endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("illegal mode switch taken");

  property p_flags;
    (full || empty) == (wr_ptr_r == rd_ptr_r) && !(full && empty);
  endproperty
  a_flags: assert property (p_flags) else $error("full and empty disagree");

endmodule : ecpr_port_regs

// [design/ecpr_defines.svh]
`ifndef ECPR_DEFINES_SVH
`define ECPR_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets from the port base address
// ----------------------------------------------------------------------
`define ECPR_OFF_DATA 16'h0000
`define ECPR_OFF_STATUS 16'h0001
`define ECPR_OFF_CONTROL 16'h0002
`define ECPR_OFF_QUEUE 16'h0400
`define ECPR_OFF_RESOURCE 16'h0401
`define ECPR_OFF_EXTCTRL 16'h0402

// ----------------------------------------------------------------------
// mode field codes
// ----------------------------------------------------------------------
`define ECPR_MODE_COMPAT 3'h0
`define ECPR_MODE_BYTE 3'h1
`define ECPR_MODE_STDQ 3'h2
`define ECPR_MODE_ECP 3'h3
`define ECPR_MODE_EPP 3'h4
`define ECPR_MODE_RSVD 3'h5
`define ECPR_MODE_TEST 3'h6
`define ECPR_MODE_CONFIG 3'h7

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ECPR_CTL_STROBE 0
`define ECPR_CTL_AUTOFEED 1
`define ECPR_CTL_INIT 2
`define ECPR_CTL_SELIN 3
`define ECPR_CTL_ACKIEN 4
`define ECPR_CTL_DIR 5
`define ECPR_ECR_MODE_HI 7
`define ECPR_ECR_MODE_LO 5
`define ECPR_ECR_ERRDIS 4
`define ECPR_ECR_DMA_ENABLE_BIT 3
`define ECPR_ECR_SVC 2

// ----------------------------------------------------------------------
// reset values and fixed answers
// ----------------------------------------------------------------------
`define ECPR_DATA_RST 8'h00
`define ECPR_CTRL_RST 6'h00
`define ECPR_MODE_RST 3'h0
`define ECPR_SVC_RST 1'b1
`define ECPR_IMPL_INFO 8'h10

// ----------------------------------------------------------------------
// queue sizing and service thresholds
// ----------------------------------------------------------------------
`define ECPR_FIFO_DEPTH 5'h10
`define ECPR_WRITE_THRESHOLD 5'h08
`define ECPR_READ_THRESHOLD 5'h08

`endif

// [design/ecpr_pkg.sv]
package ecpr_pkg;

  typedef logic [2:0] ecpr_mode_t;

  // transfer engine states
  typedef enum logic [4:0] {
    XF_IDLE = 5'b00001,
    XF_SETUP = 5'b00010,
    XF_STROBE = 5'b00100,
    XF_HOLD = 5'b01000,
    XF_REV = 5'b10000
  } ecpr_xfer_e;

  // host bus lines, sampled together
  typedef struct packed {
    logic wr_n;
    logic rd_n;
    logic aen;
    logic [15:0] addr;
    logic [7:0] data;
  } ecpr_host_s;

  // peripheral and system inputs, sampled together
  typedef struct packed {
    logic fault;
    logic select;
    logic paper_error_input;
    logic ack;
    logic busy;
    logic tc;
    logic irq_level;
    logic [7:0] pd;
  } ecpr_pins_s;

endpackage : ecpr_pkg

// [design/ecpr_fifo_mem.sv]
`timescale 1ns/100ps
module ecpr_fifo_mem (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic wr_en_i,
  input wire logic [3:0] wr_addr_i,
  input wire logic [8:0] wr_data_i,
  input wire logic [3:0] rd_addr_i,
  output logic [8:0] rd_data_o
);

  logic [8:0] mem_r [16];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  // read data registered; one cycle after the address settles
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 9'h000;
    end else begin
      rd_data_o <= mem_r[rd_addr_i];
    end
  end

endmodule : ecpr_fifo_mem

// [verif/ecpr_periph_model.sv]
`timescale 1ns/100ps
module ecpr_periph_model (
  input wire logic clk_i,
  input wire logic strobe_n_i,
  input wire logic [7:0] pd_i,
  input wire logic [1:0] lag_i,
  output logic busy_o,
  output logic [7:0] got_o,
  output int cnt_o
);
  initial begin
    busy_o = 1'b0;
    cnt_o = 0;
    got_o = 8'h00;
    forever begin
      @(negedge strobe_n_i);
      repeat (lag_i + 1) @(posedge clk_i);
      #1;
      got_o = pd_i;
      cnt_o++;
      busy_o = 1'b1;
      @(posedge strobe_n_i);
      repeat (lag_i + 1) @(posedge clk_i);
      #1;
      busy_o = 1'b0;
    end
  end
endmodule : ecpr_periph_model

// [verif/ecp_parallel_port_registers_tb.sv]
`timescale 1ns/100ps
module ecp_parallel_port_registers_tb;
  logic clk, rst_n, aen, rd_n, wr_n, irql, fault_n, sel, pe, ack_n, hoe_n, pdoe_n, stb_n, afd_n, init_n, sin_n;
  logic irq, busy, oes;
  logic [3:0] isel;
  logic [1:0] dsel;
  logic [1:0] lag;
  logic [15:0] base, addr;
  logic [7:0] hd, hdo, pdo, got, v, r;
  logic [7:0] q[$];
  int error_cnt = 0, samples_checked = 0, cnt, c, i, k, irqs = 0;
  ecpr_port_regs DUT (.clk_i(clk), .reset_n_i(rst_n), .base_addr_i(base), .host_addr_i(addr), .aen_i(aen),
    .host_read_strobe_n_i(rd_n), .host_write_strobe_n_i(wr_n), .host_data_i(hd), .host_data_o(hdo),
    .host_data_oe_n_o(hoe_n), .dma_tc_i(1'b0), .irq_level_i(irql), .irq_sel_i(isel), .dma_sel_i(dsel),
    .fault_input_n_i(fault_n), .select_i(sel), .paper_error_input_i(pe), .acknowledge_input_n_i(ack_n),
    .busy_i(busy), .port_data_pins_i(pdoe_n ? ~pdo : pdo), .port_data_pins_o(pdo), .port_data_oe_n_o(pdoe_n),
    .strobe_output_n_o(stb_n), .autofeed_output_n_o(afd_n), .initialize_output_n_o(init_n),
    .select_in_output_n_o(sin_n), .irq_o(irq));
  ecpr_periph_model PRN (.clk_i(clk), .strobe_n_i(stb_n), .pd_i(pdo), .lag_i(lag), .busy_o(busy), .got_o(got),
    .cnt_o(cnt));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (irq === 1'b1) irqs++;
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask : chk
  // strobes held well past the two-flop sync on both sides
  task automatic acc(input logic w, input logic [15:0] o, input logic [7:0] d, output logic [7:0] rv);
    @(negedge clk);
    addr = base + o;
    hd = d;
    if (w) wr_n = 1'b0;
    else rd_n = 1'b0;
    repeat (5) @(negedge clk);
    rv = hdo;
    oes = hoe_n;
    wr_n = 1'b1;
    rd_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask : acc
  task automatic wr(input logic [15:0] o, input logic [7:0] d);
    acc(1'b1, o, d, r);
  endtask : wr
  task automatic rc(input logic [15:0] o, input logic [7:0] e);
    acc(1'b0, o, 8'h00, r);
    chk(r, e);
  endtask : rc
  function automatic logic [7:0] stat_exp(input logic [3:0] s, input logic b);
    return {~b, s[0], s[1], s[2], s[3], 3'b000};
  endfunction : stat_exp
  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    {rd_n, wr_n, aen, irql, fault_n, sel, pe, ack_n} = 8'hC9;
    base = 16'h0378;
    {isel, dsel} = 6'h1E;
    addr = 16'h0000;
    hd = 8'h00;
    lag = 2'h0;
    rst_n = 1'b0;
    v = $urandom(32'hB88071C0);
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rc(16'h0002, 8'h00);
    chk({4'h0, stb_n, afd_n, init_n, sin_n}, 8'h0D);
    rc(16'h0000, 8'h00);
    $display("test reset done");
    for (i = 0; i < 6; i++) begin
      v = $urandom;
      {fault_n, sel, pe, ack_n} = v[3:0];
      rc(16'h0001, stat_exp(v[3:0], busy));
    end
    chk({7'h00, oes}, 8'h00);
    chk(irqs[7:0], 8'h00);
    wr(16'h0002, 8'h10);
    irqs = 0;
    ack_n = 1'b0;
    repeat (6) @(negedge clk);
    ack_n = 1'b1;
    repeat (8) @(negedge clk);
    chk(irqs[7:0], 8'h01);
    $display("test status done");
    for (i = 0; i < 4; i++) begin
      v = $urandom;
      wr(16'h0002, v);
      rc(16'h0002, {3'b000, v[4:0]});
      chk({4'h0, stb_n, afd_n, init_n, sin_n}, {4'h0, ~v[0], ~v[1], v[2], ~v[3]});
    end
    wr(16'h0002, 8'h00);
    v = $urandom;
    wr(16'h0000, v);
    chk(pdo, v);
    rc(16'h0000, v);
    wr(16'h0402, 8'h24);
    wr(16'h0002, 8'h20);
    chk({7'h00, pdoe_n}, 8'h01);
    // released pins read back inverted through the bench's bus model
    rc(16'h0000, ~v);
    wr(16'h0002, 8'h00);
    chk({7'h00, pdoe_n}, 8'h00);
    wr(16'h0402, 8'h04);
    aen = 1'b1;
    rc(16'h0001, 8'h00);
    chk({7'h00, oes}, 8'h01);
    aen = 1'b0;
    rc(16'h0003, 8'h00);
    chk({7'h00, oes}, 8'h01);
    $display("test control done");
    wr(16'h0402, 8'hE4);
    wr(16'h0400, 8'h55);
    rc(16'h0400, 8'h10);
    irql = 1'b1;
    rc(16'h0401, 8'h4A);
    {isel, dsel, irql} = 7'h5E;
    rc(16'h0401, 8'h23);
    rc(16'h0000, 8'h00);
    wr(16'h0402, 8'h04);
    wr(16'h0402, 8'hC4);
    for (i = 0; i < 17; i++) begin
      v = $urandom;
      wr(16'h0400, v);
      if (i < 16) q.push_back(v);
    end
    wr(16'h0402, 8'hC0);
    acc(1'b0, 16'h0402, 8'h00, v);
    chk(v, 8'hC2);
    for (i = 0; i < 16; i++) begin
      // seven bytes drained leaves seven free, one short of the threshold
      if (i == 7) begin
        acc(1'b0, 16'h0402, 8'h00, v);
        chk(v, 8'hC0);
      end
      rc(16'h0400, q[i]);
    end
    rc(16'h0400, q[15]);
    acc(1'b0, 16'h0402, 8'h00, v);
    chk(v, 8'hC5);
    $display("test queue done");
    wr(16'h0402, 8'h04);
    wr(16'h0402, 8'h44);
    for (i = 0; i < 3; i++) begin
      lag = i[1:0] * 2'h3;
      c = cnt;
      v = $urandom;
      wr(16'h0400, v);
      for (k = 0; k < 80 && cnt == c; k++) @(negedge clk);
      chk(got, v);
    end
    wr(16'h0402, 8'h04);
    wr(16'h0402, 8'h64);
    for (i = 0; i < 2; i++) begin
      c = cnt;
      v = $urandom;
      wr(i ? 16'h0400 : 16'h0000, v);
      for (k = 0; k < 80 && cnt == c; k++) @(negedge clk);
      chk(got, v);
      // autofeed low marks the byte from offset 0 as an address
      chk({7'h00, afd_n}, {7'h00, i[0]});
    end
    wr(16'h0402, 8'h04);
    $display("test forward done");
    summarize();
  end
endmodule : ecp_parallel_port_registers_tb
